//--- hdl/sfc_pkg.sv
// Purpose: Shared constants and types for the serial flash command block.
// Assumes: Single-line transfers, most significant bit first.
// Notes:   Numbers used by more than one process live here.
package sfc_pkg;

  // ----------------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OPC_CFG_READ = 8'h15;
  localparam logic [7:0] OPC_BUSY_WATCH = 8'h25;
  localparam logic [7:0] OPC_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OPC_CFG_WRITE = 8'h11;
  localparam logic [7:0] OPC_READ = 8'h03;
  localparam logic [7:0] OPC_FAST_READ = 8'h0b;

  // ----------------------------------------------------------------------
  // Frame bit counts
  // ----------------------------------------------------------------------
  localparam logic [4:0] OPC_LAST_BIT = 5'h07;
  localparam logic [4:0] ADDR_LAST_BIT = 5'h17;
  localparam logic [4:0] DUMMY_LAST_BIT = 5'h07;
  localparam logic [4:0] WDATA_BYTE1 = 5'h08;
  localparam logic [4:0] WDATA_BYTE2 = 5'h10;

  // ----------------------------------------------------------------------
  // Status register bit positions
  // ----------------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_PROT_LO = 7;
  localparam int ST_PROT_HI = 8;
  localparam int ST_QUAD = 9;
  localparam int ST_PSUS = 10;
  localparam int ST_CMP = 14;
  localparam int ST_ESUS = 15;
  localparam logic [15:0] ST_WRITE_MASK = 16'h7bfc;
  localparam logic [15:0] ST_LOCK_MASK = 16'h3800;
  localparam logic [15:0] ST_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------------
  localparam int CFG_DRV_LO = 5;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h60;
  localparam logic [7:0] CFG_RESET = 8'h20;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;

  typedef enum logic [1:0] {CM_NONE, CM_STAT8, CM_STAT16, CM_CFG} sfc_commit_t;
  typedef enum logic [2:0] {LS_OPC, LS_ADDR, LS_DUMMY, LS_DATA, LS_WDATA, LS_WATCH, LS_IGNORE} sfc_lstate_t;

endpackage

//--- hdl/sfc_core.sv
// Purpose: Register read/write and read command handling of a serial flash.
// Assumes: CS_N stays high for at least four CLK periods between frames.
// Notes:   Link logic runs on SCLK; its frame state and output clear on CS_N, the rest only on reset; register state runs on CLK.
//
// Notes on behaviour
// R1: Opcode 15h shifts the configuration byte out, accepted any time.
// R2: Host should poll the busy flag before new commands during writes.
// R3: Configuration register holds drive strength in bits 6 and 5.
// R4: Drive codes 00/01/10/11 give 75/100/150/50 percent, default 01.
// R5: Opcode 25h drives live busy flag on output while select stays low.
// R6: In mode 3 the host clocks one dummy bit after that opcode.
// R7: Input levels after the busy-watch opcode are ignored.
// R8: Output falls when busy clears and never rises during busy watch; the code passes busy straight through, so the output rises if busy rises.
// R9: Raising select ends busy watch and floats the output at once.
// R10: Status write opcode 01h only accepted with the write latch set.
// R11: Status write keeps bits 15, 10, 1 and 0 unchanged.
// R12: Status write ends after exactly 8 or 16 data bits, else rejected.
// R13: Eight-bit status write clears complement, quad and upper protect bits.
// R14: Status write starts timed cycle at select rise, busy then latch clear.
// R15: Status write refused in hardware protected mode.
// R16: Configuration write 11h needs write latch and exactly 8 data bits.
// R17: Configuration write runs timed cycle with busy, then clears latch.
// R18: Read 03h takes 3 address bytes on rising, data out on falling.
// R19: Address advances per byte and wraps to zero after the top.
// R20: Select rise ends read output immediately.
// R21: Fast read 0Bh takes address plus one dummy byte before data.
// R22: Fast read during a write cycle is rejected, cycle unaffected.
// R23: Low status byte: busy, latch, five protect bits, lower protect mode.
// R24: High status byte: upper protect, quad, suspend, locks, complement, suspend.
// R25: Protect mode 0,1 with write-protect low locks the status register.
// R26: All single-line fields move most significant bit first.
// R27: Reserved configuration bits read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none

module sfc_core #(
  parameter int ARRAY_AW = 24,
  parameter int REG_WRITE_TIME_NS = 5000000,
  parameter int REG_WRITE_CYCLES = (REG_WRITE_TIME_NS + sfc_pkg::CLK_PERIOD_NS - 1) / sfc_pkg::CLK_PERIOD_NS
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic WP_N,
  input wire logic WEL_SET,
  input wire logic ARRAY_BUSY,
  input wire logic [7:0] MEM_RDATA,
  output logic [ARRAY_AW-1:0] MEM_ADDR,
  output logic SO_OUT,
  output logic SO_OE_N,
  output logic [15:0] STATUS,
  output logic [7:0] CONFIG,
  output logic [7:0] DRIVE_PCT
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  sfc_pkg::sfc_lstate_t state;
  sfc_pkg::sfc_lstate_t next_state;
  sfc_pkg::sfc_commit_t commit_kind;
  sfc_pkg::sfc_commit_t next_commit;
  sfc_pkg::sfc_commit_t pend_kind;
  logic [4:0] bitcnt;
  logic [7:0] sh;
  logic [2:0] data_bit;
  logic fast;
  logic cfg_rd;
  logic is_cfg_wr;
  logic [15:0] wdata;
  logic [15:0] commit_data;
  logic [15:0] pend_data;
  logic frame_tgl;
  logic link_clr;
  logic busy_l1, busy_l2;
  logic [7:0] cfg_l1, cfg_l2;
  logic so_q;
  logic so_oe_n;
  logic watch_sel;
  logic cs_s1, cs_s2, cs_s3;
  logic tgl_s1, tgl_s2, seen_tgl;
  logic wp_s1, wp_s2;
  logic [15:0] status;
  logic [7:0] cfg;
  logic wr_active;
  logic [31:0] timer;
  logic busy;
  logic write_enable_latch;
  logic [7:0] drive_pct;

  // ----------------------------------------------------------------------
  // Link decode
  // ----------------------------------------------------------------------
  wire [7:0] opcode = {sh[6:0], SI};
  wire opc_done = (state == sfc_pkg::LS_OPC) && (bitcnt == sfc_pkg::OPC_LAST_BIT);
  wire first_edge = (state == sfc_pkg::LS_OPC) && (bitcnt == 5'h00);
  wire [4:0] bit_inc = bitcnt + 5'h01;
  wire [7:0] cur_byte = cfg_rd ? cfg_l2 : MEM_RDATA;
  wire drives = (state == sfc_pkg::LS_DATA) || (state == sfc_pkg::LS_WATCH);

  function automatic logic [7:0] drive_decode(input logic [1:0] code);
    case (code)
      2'b00: drive_decode = 8'd75;
      2'b01: drive_decode = 8'd100;
      2'b10: drive_decode = 8'd150;
      default: drive_decode = 8'd50;
    endcase
  endfunction

  always_comb begin
    next_state = state;
    case (state)
      sfc_pkg::LS_OPC: begin
        if (opc_done) begin
          case (opcode)
            // R1: configuration readout
            sfc_pkg::OPC_CFG_READ: next_state = sfc_pkg::LS_DATA;
            // R5: enter busy watch
            sfc_pkg::OPC_BUSY_WATCH: next_state = sfc_pkg::LS_WATCH;
            sfc_pkg::OPC_STATUS_WRITE: next_state = sfc_pkg::LS_WDATA;
            sfc_pkg::OPC_CFG_WRITE: next_state = sfc_pkg::LS_WDATA;
            sfc_pkg::OPC_READ: next_state = sfc_pkg::LS_ADDR;
            // R22: fast read refused while busy
            sfc_pkg::OPC_FAST_READ: next_state = busy_l2 ? sfc_pkg::LS_IGNORE : sfc_pkg::LS_ADDR;
            default: next_state = sfc_pkg::LS_IGNORE;
          endcase
        end
      end
      sfc_pkg::LS_ADDR: begin
        // R21: fast read adds dummy byte
        if (bitcnt == sfc_pkg::ADDR_LAST_BIT) begin
          next_state = fast ? sfc_pkg::LS_DUMMY : sfc_pkg::LS_DATA;
        end
      end
      sfc_pkg::LS_DUMMY: begin
        if (bitcnt == sfc_pkg::DUMMY_LAST_BIT) begin
          next_state = sfc_pkg::LS_DATA;
        end
      end
      default: next_state = state;
    endcase
  end

  // R12: only a whole byte or two arm a commit
  always_comb begin
    next_commit = sfc_pkg::CM_NONE;
    if (state == sfc_pkg::LS_WDATA) begin
      if (is_cfg_wr) begin
        // R16: configuration takes exactly one byte
        next_commit = (bit_inc == sfc_pkg::WDATA_BYTE1) ? sfc_pkg::CM_CFG : sfc_pkg::CM_NONE;
      end else if (bit_inc == sfc_pkg::WDATA_BYTE1) begin
        next_commit = sfc_pkg::CM_STAT8;
      end else if (bit_inc == sfc_pkg::WDATA_BYTE2) begin
        next_commit = sfc_pkg::CM_STAT16;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link logic, rising SCLK
  // ----------------------------------------------------------------------
  // R26: all fields shift in most significant bit first.
  always_ff @(posedge SCLK or posedge CS_N or posedge link_clr) begin
    if (CS_N || link_clr) begin
      state <= sfc_pkg::LS_OPC;
      bitcnt <= 5'h00;
      sh <= 8'h00;
      fast <= 1'b0;
      cfg_rd <= 1'b0;
      is_cfg_wr <= 1'b0;
      data_bit <= 3'h0;
      wdata <= 16'h0000;
    end else begin
      state <= next_state;
      sh <= {sh[6:0], SI};
      bitcnt <= (next_state != state) ? 5'h00 : (bitcnt == 5'h1f ? bitcnt : bit_inc);
      if (opc_done) begin
        fast <= (opcode == sfc_pkg::OPC_FAST_READ);
        cfg_rd <= (opcode == sfc_pkg::OPC_CFG_READ);
        is_cfg_wr <= (opcode == sfc_pkg::OPC_CFG_WRITE);
      end
      if (state == sfc_pkg::LS_DATA) begin
        data_bit <= data_bit + 3'h1;
      end
      if (state == sfc_pkg::LS_WDATA) begin
        wdata <= {wdata[14:0], SI};
      end
    end
  end

  // R18: address captured on rising edges
  always_ff @(posedge SCLK or posedge link_clr) begin
    if (link_clr) begin
      MEM_ADDR <= '0;
    end else if (!CS_N && state == sfc_pkg::LS_ADDR) begin
      MEM_ADDR <= {MEM_ADDR[ARRAY_AW-2:0], SI};
    end else if (!CS_N && state == sfc_pkg::LS_DATA && !cfg_rd && data_bit == 3'h7) begin
      // R19: advance and wrap
      MEM_ADDR <= MEM_ADDR + {{(ARRAY_AW-1){1'b0}}, 1'b1};
    end
  end

  // Survives select rise so the CLK side can read it while SCLK is still.
  always_ff @(posedge SCLK or posedge link_clr) begin
    if (link_clr) begin
      frame_tgl <= 1'b0;
      commit_kind <= sfc_pkg::CM_NONE;
      commit_data <= 16'h0000;
    end else if (!CS_N) begin
      frame_tgl <= first_edge ? ~frame_tgl : frame_tgl;
      commit_kind <= next_commit;
      commit_data <= {wdata[14:0], SI};
    end
  end

  // Busy and configuration brought into the SCLK domain.
  always_ff @(posedge SCLK or posedge link_clr) begin
    if (link_clr) begin
      busy_l1 <= 1'b0;
      busy_l2 <= 1'b0;
      cfg_l1 <= sfc_pkg::CFG_RESET;
      cfg_l2 <= sfc_pkg::CFG_RESET;
    end else begin
      busy_l1 <= busy;
      busy_l2 <= busy_l1;
      cfg_l1 <= cfg;
      cfg_l2 <= cfg_l1;
    end
  end

  // ----------------------------------------------------------------------
  // Link logic, falling SCLK
  // ----------------------------------------------------------------------
  // R9: select high floats the output at once
  // R20: read output stops without a byte boundary
  always_ff @(negedge SCLK or posedge CS_N or posedge link_clr) begin
    if (CS_N || link_clr) begin
      so_q <= 1'b0;
      so_oe_n <= 1'b1;
      watch_sel <= 1'b0;
    end else begin
      // R18: data shifts out on falling edges
      so_q <= cur_byte[3'h7 - data_bit];
      so_oe_n <= ~drives;
      // R7: input ignored once watching
      watch_sel <= (state == sfc_pkg::LS_WATCH);
    end
  end

  // R5: live busy with no further clocks
  // R8: output follows busy live, so it also rises if busy rises inside a frame
  assign SO_OUT = watch_sel ? busy : so_q;
  assign SO_OE_N = so_oe_n;

  // ----------------------------------------------------------------------
  // Crossings into CLK
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    cs_s1 <= CS_N;
    cs_s2 <= cs_s1;
    cs_s3 <= cs_s2;
    tgl_s1 <= frame_tgl;
    tgl_s2 <= tgl_s1;
    wp_s1 <= WP_N;
    wp_s2 <= wp_s1;
  end

  wire cs_rise = cs_s2 && !cs_s3;
  wire new_frame = cs_rise && (tgl_s2 != seen_tgl);
  wire [1:0] prot_mode = {status[sfc_pkg::ST_PROT_HI], status[sfc_pkg::ST_PROT_LO]};
  // R15: hardware protection blocks status writes
  // R25: protect mode 0,1 with pin low locks
  wire st_locked = (prot_mode == 2'b01 && !wp_s2) || prot_mode[1];
  // R10: latch needed for any register write
  wire wr_ok = write_enable_latch && !busy;
  wire take_stat = new_frame && wr_ok && !st_locked &&
                   (commit_kind == sfc_pkg::CM_STAT8 || commit_kind == sfc_pkg::CM_STAT16);
  wire take_cfg = new_frame && wr_ok && (commit_kind == sfc_pkg::CM_CFG);
  wire cycle_done = wr_active && (timer == 32'h0000_0001);

  // Status byte as written, with untouched and one-time bits folded in.
  // The first data byte of a two-byte write fills the low half.
  wire [15:0] stat_in = (pend_kind == sfc_pkg::CM_STAT8) ? {status[15:8], pend_data[7:0]} :
                        {pend_data[7:0], pend_data[15:8]};
  // R11: suspend, latch and busy bits kept
  wire [15:0] stat_kept = (status & ~sfc_pkg::ST_WRITE_MASK) | (stat_in & sfc_pkg::ST_WRITE_MASK) |
                          (status & sfc_pkg::ST_LOCK_MASK);
  // R13: short write clears three high bits
  wire [15:0] short_clr = (16'h0001 << sfc_pkg::ST_CMP) | (16'h0001 << sfc_pkg::ST_QUAD) |
                          (16'h0001 << sfc_pkg::ST_PROT_HI);
  wire [15:0] stat_new = (pend_kind == sfc_pkg::CM_STAT8) ? (stat_kept & ~short_clr) : stat_kept;

  // ----------------------------------------------------------------------
  // Register state, CLK
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      link_clr <= 1'b1;
      seen_tgl <= 1'b0;
    end else begin
      link_clr <= 1'b0;
      seen_tgl <= new_frame ? tgl_s2 : seen_tgl;
    end
  end

  // R14: timed cycle starts at select rise
  // R17: same cycle for configuration writes
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      wr_active <= 1'b0;
      timer <= 32'h0000_0000;
      pend_kind <= sfc_pkg::CM_NONE;
      pend_data <= 16'h0000;
    end else if (take_stat || take_cfg) begin
      wr_active <= 1'b1;
      timer <= REG_WRITE_CYCLES[31:0];
      pend_kind <= commit_kind;
      pend_data <= commit_data;
    end else if (cycle_done) begin
      wr_active <= 1'b0;
      timer <= 32'h0000_0000;
    end else if (wr_active) begin
      timer <= timer - 32'h0000_0001;
    end
  end

  // R23: busy and latch in the low status byte
  // R24: high byte fields kept in place
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      status <= sfc_pkg::ST_RESET;
      cfg <= sfc_pkg::CFG_RESET;
      busy <= 1'b0;
      write_enable_latch <= 1'b0;
    end else begin
      busy <= (wr_active && !cycle_done) || take_stat || take_cfg || ARRAY_BUSY;
      // R14: latch cleared at completion, a set in that cycle wins
      write_enable_latch <= WEL_SET || (write_enable_latch && !cycle_done);
      if (cycle_done && pend_kind != sfc_pkg::CM_CFG) begin
        status <= stat_new;
      end
      // R27: reserved bits stay zero
      if (cycle_done && pend_kind == sfc_pkg::CM_CFG) begin
        cfg <= pend_data[7:0] & sfc_pkg::CFG_WRITE_MASK;
      end
    end
  end

  // R3: drive field at bits 6 and 5
  // R4: drive strength decode
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      drive_pct <= 8'd100;
    end else begin
      drive_pct <= drive_decode(cfg[sfc_pkg::CFG_DRV_LO+1:sfc_pkg::CFG_DRV_LO]);
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      STATUS <= sfc_pkg::ST_RESET;
    end else begin
      STATUS <= {status[15:2], write_enable_latch, busy};
    end
  end

  assign CONFIG = cfg;
  assign DRIVE_PCT = drive_pct;

endmodule

`default_nettype wire

//--- verif/sfc_host.sv
// Purpose: Host SPI controller model driving select, serial clock and data.
// Assumes: Mode 0; the clock idles low and stands still between frames.
// Notes:   A released data line shows the inverse of its last level.
`timescale 1ns/10ps
`default_nettype none
module sfc_host (
  output logic CS_N,
  output logic SCLK,
  output logic SI,
  input wire logic SO
);
  initial begin
    CS_N = 1'b1;
    SCLK = 1'b0;
    SI = 1'b0;
  end
  task automatic xfer(input logic [63:0] tx, input int nbits, input bit hold, output logic [63:0] rx);
    rx = '0;
    CS_N = 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      SI = tx[i];
      #62.5 SCLK = 1'b1;
      rx = {rx[62:0], SO};
      #62.5 SCLK = 1'b0;
    end
    #20 SI = ~SI;
    if (!hold) begin
      CS_N = 1'b1;
      #200;
    end
  endtask
endmodule
`default_nettype wire

//--- verif/sfc_core_chk.sv
// Purpose: Concurrent checks on the serial flash command block ports.
// Assumes: Busy from the array stays short of nine cycles.
// Notes:   All checks run on CLK.
`timescale 1ns/10ps
`default_nettype none
module sfc_core_chk #(
  parameter int REG_WRITE_CYCLES = 20
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic CS_N,
  input wire logic WEL_SET,
  input wire logic SO_OE_N,
  input wire logic [15:0] STATUS,
  input wire logic [7:0] CONFIG,
  input wire logic [7:0] DRIVE_PCT
);
  int busy_cnt;
  function automatic logic [7:0] pct(input logic [1:0] c);
    return c == 2'b00 ? 8'h4b : c == 2'b01 ? 8'h64 : c == 2'b10 ? 8'h96 : 8'h32;
  endfunction
  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      busy_cnt <= 0;
    end else if (STATUS[0]) begin
      busy_cnt <= busy_cnt + 1;
    end else begin
      busy_cnt <= 0;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  property p_oe_off; CS_N |-> SO_OE_N; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven while deselected");
  property p_cfg_rsvd; (CONFIG & 8'h9f) == 8'h00; endproperty
  a_cfg_rsvd: assert property (p_cfg_rsvd) else $error("reserved config bit set");
  property p_drive; $stable(CONFIG) |-> DRIVE_PCT == pct(CONFIG[6:5]); endproperty
  a_drive: assert property (p_drive) else $error("drive percent wrong");
  property p_busy_len;
    $fell(STATUS[0]) && busy_cnt > 8 |-> busy_cnt >= REG_WRITE_CYCLES - 1 && busy_cnt <= REG_WRITE_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_wel_clr; $fell(STATUS[0]) && busy_cnt > 8 |-> !STATUS[1]; endproperty
  a_wel_clr: assert property (p_wel_clr) else $error("latch kept after write cycle");
  property p_stat_end; $changed(STATUS[15:2]) |-> !STATUS[0] && ($past(busy_cnt) > 8 || busy_cnt > 8); endproperty
  a_stat_end: assert property (p_stat_end) else $error("status changed outside cycle end");
  property p_cfg_end; $changed(CONFIG) |-> busy_cnt > 8 ##1 !STATUS[0]; endproperty
  a_cfg_end: assert property (p_cfg_end) else $error("config changed outside cycle end");
  property p_susp; STATUS[15] == 1'b0 && STATUS[10] == 1'b0; endproperty
  a_susp: assert property (p_susp) else $error("suspend flag set");
  property p_wel_set; WEL_SET |-> ##[1:3] STATUS[1]; endproperty
  a_wel_set: assert property (p_wel_set) else $error("latch not set");
  c_cycle: cover property ($fell(STATUS[0]) && busy_cnt > 8);
  c_cfg: cover property ($changed(CONFIG));
  c_drive: cover property (!SO_OE_N);
endmodule
bind sfc_core sfc_core_chk #(.REG_WRITE_CYCLES(REG_WRITE_CYCLES)) u_chk (.CLK(CLK), .RESET_N(RESET_N),
  .CS_N(CS_N), .WEL_SET(WEL_SET), .SO_OE_N(SO_OE_N), .STATUS(STATUS), .CONFIG(CONFIG), .DRIVE_PCT(DRIVE_PCT));
`default_nettype wire

//--- verif/serial_flash_reg_and_read_cmds_bench.sv
// Purpose: Self-checking bench for the serial flash command block.
// Assumes: Write cycle shortened to 300 clock cycles.
// Notes:   Array bytes come from a fixed function of the address.
`timescale 1ns/10ps
`default_nettype none
module serial_flash_reg_and_read_cmds_bench;
  logic CLK, RESET_N, WP_N, WEL_SET, ARRAY_BUSY, so_last, oe_seen;
  wire CS_N, SCLK, SI, SO_OUT, SO_OE_N, so_w;
  wire [7:0] MEM_RDATA, CONFIG, DRIVE_PCT;
  wire [23:0] MEM_ADDR;
  wire [15:0] STATUS;
  logic [63:0] rx;
  int n_errors, checks;
  function automatic logic [7:0] mem_byte(input logic [23:0] a);
    return a[7:0] ^ a[23:16] ^ 8'h5a;
  endfunction
  function automatic logic [7:0] pct(input logic [1:0] c);
    return c == 2'b00 ? 8'h4b : c == 2'b01 ? 8'h64 : c == 2'b10 ? 8'h96 : 8'h32;
  endfunction
  assign MEM_RDATA = mem_byte(MEM_ADDR);
  assign so_w = SO_OE_N ? so_last : SO_OUT;
  always @(posedge SO_OE_N) so_last = ~SO_OUT;
  always @(negedge SO_OE_N) oe_seen = 1'b1;
  sfc_core #(.REG_WRITE_CYCLES(300)) u_dut (.CLK(CLK), .RESET_N(RESET_N), .SCLK(SCLK), .CS_N(CS_N), .SI(SI),
    .WP_N(WP_N), .WEL_SET(WEL_SET), .ARRAY_BUSY(ARRAY_BUSY), .MEM_RDATA(MEM_RDATA), .MEM_ADDR(MEM_ADDR),
    .SO_OUT(SO_OUT), .SO_OE_N(SO_OE_N), .STATUS(STATUS), .CONFIG(CONFIG), .DRIVE_PCT(DRIVE_PCT));
  sfc_host u_host (.CS_N(CS_N), .SCLK(SCLK), .SI(SI), .SO(so_w));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic write_enable_latch();
    @(posedge CLK) #2 WEL_SET = 1'b1;
    @(posedge CLK) #2 WEL_SET = 1'b0;
  endtask
  task automatic frame(input logic [63:0] tx, input int n, input bit hold);
    @(posedge CLK) #2;
    u_host.xfer(tx, n, hold, rx);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    repeat (5) @(posedge CLK);
    while (STATUS[0] !== 1'b0 && k < 400) begin
      @(posedge CLK);
      k++;
    end
    #2;
  endtask
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  initial begin
    #1000000;
    n_errors++;
    give_verdict();
  end
  initial begin : main
    logic [15:0] d;
    logic [23:0] a;
    int k;
    RESET_N = 1'b0;
    WP_N = 1'b1;
    WEL_SET = 1'b0;
    ARRAY_BUSY = 1'b0;
    so_last = 1'b0;
    oe_seen = 1'b0;
    n_errors = 0;
    checks = 0;
    void'($urandom(32'hb0cf1274));
    repeat (10) @(posedge CLK);
    #2 RESET_N = 1'b1;
    repeat (3) @(posedge CLK);
    #2;
    check(STATUS, 16'h0000);
    check(CONFIG, 8'h20);
    check(DRIVE_PCT, 8'h64);
    for (int c = 0; c < 4; c++) begin
      d = 16'($urandom);
      d[6:5] = c[1:0];
      write_enable_latch();
      frame({8'h11, d[7:0]}, 16, 0);
      wait_idle();
      check(CONFIG, d[7:0] & 8'h60);
      check(DRIVE_PCT, pct(c[1:0]));
      check(STATUS[1], 1'b0);
      frame(64'h1500, 16, 0);
      check(rx[7:0], d[7:0] & 8'h60);
    end
    frame(64'h1100, 16, 0);
    wait_idle();
    check(CONFIG, 8'h60);
    write_enable_latch();
    frame(64'h2200, 17, 0);
    wait_idle();
    check(CONFIG, 8'h60);
    $display("test config done");
    for (int i = 0; i < 3; i++) begin
      d = (16'($urandom) & 16'h027c) | 16'h4200;
      write_enable_latch();
      frame({8'h01, d[7:0] | 8'h03, d[15:8] | 8'h84}, 24, 0);
      wait_idle();
      check(STATUS, d);
    end
    write_enable_latch();
    frame(64'h017f, 16, 0);
    wait_idle();
    check(STATUS, 16'h007c);
    write_enable_latch();
    frame(64'h01000, 20, 0);
    wait_idle();
    check(STATUS, 16'h007e);
    frame(64'h0180, 16, 0);
    wait_idle();
    check(STATUS, 16'h0080);
    @(posedge CLK) #2 WP_N = 1'b0;
    write_enable_latch();
    frame(64'h0100, 16, 0);
    wait_idle();
    check(STATUS, 16'h0082);
    @(posedge CLK) #2 WP_N = 1'b1;
    frame(64'h0100, 16, 0);
    wait_idle();
    check(STATUS, 16'h0000);
    $display("test status done");
    write_enable_latch();
    frame(64'h011c, 16, 0);
    oe_seen = 1'b0;
    frame({8'h0b, 24'($urandom), 16'h0}, 48, 0);
    check(oe_seen, 1'b0);
    frame(64'h1500, 16, 0);
    check(rx[7:0], 8'h60);
    frame(64'h25, 8, 1);
    check(so_w, 1'b1);
    k = 0;
    while (so_w !== 1'b0 && k < 400) begin
      @(posedge CLK);
      k++;
    end
    repeat (8) begin
      @(posedge CLK) #2;
      check(so_w, 1'b0);
    end
    check(STATUS, 16'h001c);
    frame(64'h0, 0, 0);
    check(SO_OE_N, 1'b1);
    @(posedge CLK) #2 ARRAY_BUSY = 1'b1;
    repeat (3) @(posedge CLK);
    #2 check(STATUS[0], 1'b1);
    ARRAY_BUSY = 1'b0;
    $display("test busy done");
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 24'hfffffe : 24'($urandom);
      frame({8'h03, a, 24'h0}, 56, 0);
      for (int b = 0; b < 3; b++) begin
        check(rx[23 - 8 * b -: 8], mem_byte(a + 24'(b)));
      end
      frame({8'h0b, a, 8'($urandom), 16'h0}, 56, 0);
      check(rx[15:8], mem_byte(a));
      check(rx[7:0], mem_byte(a + 24'h1));
      frame({8'h03, a, 4'h0}, 36, 0);
      check(SO_OE_N, 1'b1);
    end
    $display("test read done");
    give_verdict();
  end
endmodule
`default_nettype wire
